/* File: hw/drs_sequencer.v */
// What this block does
// RULE_01: boost starts on supply, any pin, bit
// RULE_02: positive rail needs pin, boost done, bit
// RULE_03: negative rail at later of delay, pin
// RULE_04: sequencing bit removes negative power-on delay
// RULE_05: option bit picks long or short soft-start
// RULE_06: sequencing off: both rails start together
// RULE_07: soft-start lengths set for default voltages
// RULE_08: low pins shut their rails, both: all
// RULE_09: option bit picks delayed or immediate power-off
// RULE_10: supply lockout drops every rail at once
// RULE_11: discharge on negative fall, release, re-enable
// RULE_12: enable register bits gate negative, positive
// RULE_13: register writes take effect at stop
// RULE_14: enable bit six: negative with positive
// RULE_15: host lowers pins before disabling by register
// RULE_16: pin-only host leaves enable bits set
// RULE_17: tied pins: positive first, negative later
// RULE_18: rail enable bits reset to one
// RULE_19: enable pins assumed low when unconnected
// RULE_20: every interval is a timebase counter
`timescale 1ns/10ps
`default_nettype none
`include "drs_consts.vh"

module drs_sequencer #(
    parameter TW = 18,
    // RULE_07 nominal lengths; fixed, not scaled with the programmed voltage
    parameter integer T_BST_CYC  = `DRS_T_BST_SS_US * `DRS_CLK_MHZ,
    parameter integer T_PL_CYC   = `DRS_T_SS_LONG_P_US * `DRS_CLK_MHZ,
    parameter integer T_NL_CYC   = `DRS_T_SS_LONG_N_US * `DRS_CLK_MHZ,
    parameter integer T_SH_CYC   = `DRS_T_SS_SHORT_US * `DRS_CLK_MHZ,
    parameter integer T_DLY_CYC  = `DRS_T_DELAY_US * `DRS_CLK_MHZ
) (
    input  wire                   clk_sys,
    input  wire                   resetn,
    input  wire                   ce,
    input  wire                   positive_enable_pin,
    input  wire                   negative_enable_pin,
    input  wire                   input_supply_ok,
    input  wire                   reg_wr_en,
    input  wire                   reg_rd_en,
    input  wire [`DRS_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   i2c_stop,
    output reg  [7:0]             reg_rdata_q,
    output reg                    boost_rail_en_q,
    output reg                    positive_rail_en_q,
    output reg                    negative_rail_en_q,
    output wire                   boost_ss_busy,
    output wire                   positive_ss_busy,
    output wire                   negative_ss_busy,
    output reg                    positive_discharge_en_q
);

    localparam [TW-1:0] L_BST = T_BST_CYC[TW-1:0];
    localparam [TW-1:0] L_PL  = T_PL_CYC[TW-1:0];
    localparam [TW-1:0] L_NL  = T_NL_CYC[TW-1:0];
    localparam [TW-1:0] L_SH  = T_SH_CYC[TW-1:0];
    localparam [TW-1:0] L_DLY = T_DLY_CYC[TW-1:0];

    // pin synchronisers
    reg p_m_q;
    reg p_s_q;
    reg n_m_q;
    reg n_s_q;
    reg u_m_q;
    reg u_s_q;
    reg p_prev_q;
    reg n_prev_q;

    // committed and staged registers
    reg [7:0] en_q;
    reg [7:0] seq_q;
    reg [7:0] opt_q;
    reg [7:0] en_pend_q;
    reg [7:0] seq_pend_q;
    reg [7:0] opt_pend_q;
    reg       en_pv_q;
    reg       seq_pv_q;
    reg       opt_pv_q;

    reg bst_rdy_q;
    reg ndly_ok_q;

    wire bst_busy;
    wire bst_done;
    wire pos_busy;
    wire neg_busy;
    wire ndly_busy;
    wire ndly_done;
    wire off_busy;
    wire dis_done;

    wire p_fall   = p_prev_q & ~p_s_q;
    wire n_fall   = n_prev_q & ~n_s_q;
    wire uv_ok    = u_s_q;
    wire ss_long  = opt_q[`DRS_OPT_SS_LONG];
    wire off_imm  = opt_q[`DRS_OPT_OFF_IMM];
    wire en_bst   = en_q[`DRS_EN_BST];
    wire en_neg   = en_q[`DRS_EN_NEG];
    wire en_pos   = en_q[`DRS_EN_POS];
    // RULE_04 sequencing bit, RULE_14 enable bit six
    wire together = seq_q[`DRS_SEQ_DIS] | en_q[`DRS_EN_TOGETHER];

    // RULE_09 delayed power-off only when the option bit is clear
    wire off_start = p_fall & positive_rail_en_q & ~off_imm & en_pos &
                     uv_ok;
    wire off_clr   = ~uv_ok | p_s_q | ~en_pos;
    // hold from the fall cycle on, before the counter reports busy
    wire off_run   = off_busy | off_start;

    // RULE_09 positive held while the power-off delay runs
    wire pos_hold = positive_rail_en_q & off_run;

    // RULE_01 boost needs supply, a pin (or hold) and bit
    wire bst_want = uv_ok & en_bst & (p_s_q | n_s_q | pos_hold);

    // RULE_02 positive needs pin, boost done and bit
    wire pos_want = bst_want & bst_rdy_q & en_pos & (p_s_q | off_run);

    // RULE_03 later of delay expiry and pin; RULE_06 bypass
    wire neg_want = bst_want & bst_rdy_q & en_neg & n_s_q &
                    (ndly_ok_q | together);

    wire pos_rise = pos_want & ~positive_rail_en_q;
    wire neg_rise = neg_want & ~negative_rail_en_q;

    // RULE_17 negative delay restarts when positive comes up later
    wire ndly_start = bst_done | (pos_rise & ~negative_rail_en_q &
                                  bst_rdy_q);

    // RULE_05 long or short soft-start per option bit
    wire [TW-1:0] pos_len = ss_long ? L_PL : L_SH;
    wire [TW-1:0] neg_len = ss_long ? L_NL : L_SH;

    // RULE_19 pins pulled low outside, so resets sample low
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            p_m_q    <= 1'b0;
            p_s_q    <= 1'b0;
            n_m_q    <= 1'b0;
            n_s_q    <= 1'b0;
            u_m_q    <= 1'b0;
            u_s_q    <= 1'b0;
            p_prev_q <= 1'b0;
            n_prev_q <= 1'b0;
        end else if (ce) begin
            p_m_q    <= positive_enable_pin;
            p_s_q    <= p_m_q;
            n_m_q    <= negative_enable_pin;
            n_s_q    <= n_m_q;
            u_m_q    <= input_supply_ok;
            u_s_q    <= u_m_q;
            p_prev_q <= p_s_q;
            n_prev_q <= n_s_q;
        end
    end

    // register staging; a write in the stop cycle stays pending
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // RULE_18 rail enable bits come out of reset set
            en_q       <= `DRS_RST_ENABLE;
            seq_q      <= `DRS_RST_SEQ;
            opt_q      <= `DRS_RST_OPT;
            en_pend_q  <= `DRS_RST_ENABLE;
            seq_pend_q <= `DRS_RST_SEQ;
            opt_pend_q <= `DRS_RST_OPT;
            en_pv_q    <= 1'b0;
            seq_pv_q   <= 1'b0;
            opt_pv_q   <= 1'b0;
        end else if (ce) begin
            // RULE_13 staged bytes commit at the stop condition
            if (i2c_stop) begin
                if (en_pv_q) begin
                    en_q <= en_pend_q;
                end
                if (seq_pv_q) begin
                    seq_q <= seq_pend_q;
                end
                if (opt_pv_q) begin
                    opt_q <= opt_pend_q;
                end
                en_pv_q  <= 1'b0;
                seq_pv_q <= 1'b0;
                opt_pv_q <= 1'b0;
            end
            if (reg_wr_en) begin
                case (reg_addr)
                    // RULE_12 bits gate negative and positive rails
                    `DRS_ADDR_ENABLE: begin
                        en_pend_q <= reg_wdata;
                        en_pv_q   <= 1'b1;
                    end
                    `DRS_ADDR_SEQ: begin
                        seq_pend_q <= reg_wdata;
                        seq_pv_q   <= 1'b1;
                    end
                    `DRS_ADDR_OPT: begin
                        opt_pend_q <= reg_wdata;
                        opt_pv_q   <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= `DRS_RDATA_NONE;
        end else if (ce && reg_rd_en) begin
            case (reg_addr)
                `DRS_ADDR_ENABLE: reg_rdata_q <= en_q;
                `DRS_ADDR_SEQ:    reg_rdata_q <= seq_q;
                `DRS_ADDR_OPT:    reg_rdata_q <= opt_q;
                default:          reg_rdata_q <= `DRS_RDATA_NONE;
            endcase
        end
    end

    // rail state; RULE_10 lockout falls through every want term
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boost_rail_en_q    <= 1'b0;
            bst_rdy_q          <= 1'b0;
            positive_rail_en_q <= 1'b0;
            negative_rail_en_q <= 1'b0;
            ndly_ok_q          <= 1'b0;
        end else if (ce) begin
            // RULE_08 rails follow their pins, boost needs either
            boost_rail_en_q    <= bst_want;
            positive_rail_en_q <= pos_want;
            negative_rail_en_q <= neg_want;
            // RULE_20 boost completion from its counter expiry
            if (!bst_want) begin
                bst_rdy_q <= 1'b0;
            end else if (bst_done) begin
                bst_rdy_q <= 1'b1;
            end
            if (!bst_want) begin
                ndly_ok_q <= 1'b0;
            end else if (ndly_start) begin
                ndly_ok_q <= 1'b0;
            end else if (ndly_done) begin
                ndly_ok_q <= 1'b1;
            end
        end
    end

    // discharge resistor starts engaged while the rail is off
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            positive_discharge_en_q <= 1'b1;
        end else if (ce) begin
            // RULE_11 engage on falls, release after interval
            if (pos_rise) begin
                positive_discharge_en_q <= 1'b0;
            end else if (p_fall || n_fall || !uv_ok) begin
                positive_discharge_en_q <= 1'b1;
            end else if (dis_done && p_s_q) begin
                positive_discharge_en_q <= 1'b0;
            end
        end
    end

    // RULE_20 one counter per interval
    drs_interval_timer #(.TW(TW)) u_bst_ss (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (~bst_want),
        .start   (bst_want & ~boost_rail_en_q),
        .len     (L_BST),
        .busy_q  (bst_busy),
        .done_q  (bst_done)
    );

    drs_interval_timer #(.TW(TW)) u_pos_ss (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (~pos_want),
        .start   (pos_rise),
        .len     (pos_len),
        .busy_q  (pos_busy),
        .done_q  ()
    );

    drs_interval_timer #(.TW(TW)) u_neg_ss (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (~neg_want),
        .start   (neg_rise),
        .len     (neg_len),
        .busy_q  (neg_busy),
        .done_q  ()
    );

    // RULE_03 power-on delay counted from boost completion
    drs_interval_timer #(.TW(TW)) u_neg_dly (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (~bst_want),
        .start   (ndly_start),
        .len     (L_DLY),
        .busy_q  (ndly_busy),
        .done_q  (ndly_done)
    );

    // RULE_09 power-off delay after the positive pin falls
    drs_interval_timer #(.TW(TW)) u_off_dly (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (off_clr),
        .start   (off_start),
        .len     (L_DLY),
        .busy_q  (off_busy),
        .done_q  ()
    );

    // RULE_11 discharge window after the negative pin falls
    drs_interval_timer #(.TW(TW)) u_dis (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .clr     (1'b0),
        .start   (n_fall),
        .len     (L_DLY),
        .busy_q  (),
        .done_q  (dis_done)
    );

    // ramp flags come straight from the counters' busy flops
    assign boost_ss_busy    = bst_busy;
    assign positive_ss_busy = pos_busy;
    assign negative_ss_busy = neg_busy;

endmodule

`default_nettype wire

/* File: include/drs_consts.vh */
`ifndef DRS_CONSTS_VH
`define DRS_CONSTS_VH

// clock rate and interval lengths
`define DRS_CLK_MHZ        125
`define DRS_T_BST_SS_US    470
`define DRS_T_SS_LONG_P_US 1200
`define DRS_T_SS_LONG_N_US 1800
`define DRS_T_SS_SHORT_US  700
`define DRS_T_DELAY_US     2000

// register addresses
`define DRS_ADDR_W         8
`define DRS_ADDR_ENABLE    8'h02
`define DRS_ADDR_SEQ       8'h04
`define DRS_ADDR_OPT       8'h05

// reset values
`define DRS_RST_ENABLE     8'h07
`define DRS_RST_SEQ        8'h00
`define DRS_RST_OPT        8'h00
`define DRS_RDATA_NONE     8'h00

// enable register fields
`define DRS_EN_BST         0
`define DRS_EN_NEG         1
`define DRS_EN_POS         2
`define DRS_EN_TOGETHER    6

// sequencing register field
`define DRS_SEQ_DIS        4

// option register fields
`define DRS_OPT_OFF_IMM    4
`define DRS_OPT_SS_LONG    7

`endif

/* File: hw/drs_interval_timer.v */
`timescale 1ns/10ps
`default_nettype none

module drs_interval_timer #(
    parameter TW = 18
) (
    input  wire          clk_sys,
    input  wire          resetn,
    input  wire          ce,
    input  wire          clr,
    input  wire          start,
    input  wire [TW-1:0] len,
    output reg           busy_q,
    output reg           done_q
);

    reg [TW-1:0] cnt_q;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= {TW{1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q  <= len;
                busy_q <= 1'b1;
            end else if (clr) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - {{(TW-1){1'b0}}, 1'b1};
                if (cnt_q == {{(TW-1){1'b0}}, 1'b1}) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: dv/drs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module drs_sva #(
    parameter integer T_DLY_CYC = 250000
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic positive_enable_pin,
    input wire logic negative_enable_pin,
    input wire logic input_supply_ok,
    input wire logic boost_rail_en_q,
    input wire logic positive_rail_en_q,
    input wire logic negative_rail_en_q,
    input wire logic boost_ss_busy,
    input wire logic positive_discharge_en_q
);
    logic [19:0] off_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // both pins low: cycles counted, saturating
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            off_q <= 20'h00000;
        else if (positive_enable_pin || negative_enable_pin)
            off_q <= 20'h00000;
        else if (off_q != 20'hFFFFF)
            off_q <= off_q + 20'h00001;
    end
    // four samples span both sync stages and the output register
    sequence s_low(x);
        !x [*4];
    endsequence
    sequence s_rise(x);
        !x ##1 x;
    endsequence
    a_pos_boost: assert property (
        positive_rail_en_q |-> boost_rail_en_q)
        else $error("positive rail without boost");
    a_neg_boost: assert property (
        negative_rail_en_q |-> boost_rail_en_q)
        else $error("negative rail without boost");
    a_pos_after_ramp: assert property (
        s_rise(positive_rail_en_q) |-> !boost_ss_busy)
        else $error("positive rail during boost ramp");
    a_ramp_follows: assert property (
        s_rise(boost_rail_en_q) |=> boost_ss_busy)
        else $error("boost ramp not started");
    a_lockout_off: assert property (
        s_low(input_supply_ok) |-> !(boost_rail_en_q
        || positive_rail_en_q || negative_rail_en_q))
        else $error("rail on under lockout");
    a_neg_pin_off: assert property (
        s_low(negative_enable_pin) |-> !negative_rail_en_q)
        else $error("negative rail on with pin low");
    a_all_off_late: assert property (
        off_q == T_DLY_CYC + 8 |-> !(boost_rail_en_q
        || positive_rail_en_q || negative_rail_en_q))
        else $error("rail on after power-off delay");
    a_discharge_on: assert property (
        $fell(negative_enable_pin) |-> ##[2:4] positive_discharge_en_q)
        else $error("discharge not engaged");
endmodule
bind drs_sequencer drs_sva #(.T_DLY_CYC(T_DLY_CYC)) u_sva (.clk_sys,
    .resetn, .positive_enable_pin, .negative_enable_pin, .input_supply_ok,
    .boost_rail_en_q, .positive_rail_en_q, .negative_rail_en_q,
    .boost_ss_busy, .positive_discharge_en_q);
`default_nettype wire

/* File: dv/drs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module drs_host_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] reg_rdata_q,
    output var  logic       positive_enable_pin,
    output var  logic       negative_enable_pin,
    output var  logic       input_supply_ok,
    output var  logic       reg_wr_en,
    output var  logic       reg_rd_en,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       i2c_stop
);
    initial begin
        {positive_enable_pin, negative_enable_pin} = 2'b00;
        {input_supply_ok, reg_wr_en, reg_rd_en, i2c_stop} = 4'b1000;
        {reg_addr, reg_wdata} = 16'h0000;
    end
    task automatic pins(input logic p, n, s);
        @(posedge clk_sys);
        #1;
        {positive_enable_pin, negative_enable_pin} = {p, n};
        input_supply_ok = s;
    endtask
    task automatic wr(input logic [7:0] a, d, input logic s);
        @(posedge clk_sys);
        #1;
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk_sys);
        #1;
        {reg_wr_en, reg_wdata, i2c_stop} = {1'b0, ~d, s};
        @(posedge clk_sys);
        #1;
        i2c_stop = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        {reg_rd_en, reg_addr} = {1'b1, a};
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b0;
        d = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

/* File: dv/test_display_rail_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_display_rail_sequencer;
    localparam int TB = 20, TP = 40, TN = 60, TS = 30, TD = 50;
    logic        clk_sys, resetn, pp, np, ok, wen, ren, stp;
    logic        bst, pos, neg, dis, pb, nb;
    logic [7:0]  adr, wd, rdq, v;
    logic [31:0] lfsr = 32'h95657C53;
    int          mismatches = 0, n_compared = 0;
    int          t_pos, t_neg, l_pos, l_neg, m;
    drs_sequencer #(.T_BST_CYC(TB), .T_PL_CYC(TP), .T_NL_CYC(TN),
        .T_SH_CYC(TS), .T_DLY_CYC(TD)) uut (.clk_sys(clk_sys),
        .resetn(resetn), .ce(1'b1), .positive_enable_pin(pp),
        .negative_enable_pin(np), .input_supply_ok(ok), .reg_wr_en(wen),
        .reg_rd_en(ren), .reg_addr(adr), .reg_wdata(wd), .i2c_stop(stp),
        .reg_rdata_q(rdq), .boost_rail_en_q(bst), .positive_rail_en_q(pos),
        .negative_rail_en_q(neg), .boost_ss_busy(), .positive_ss_busy(pb),
        .negative_ss_busy(nb), .positive_discharge_en_q(dis));
    drs_host_model host (.clk_sys(clk_sys), .reg_rdata_q(rdq),
        .positive_enable_pin(pp), .negative_enable_pin(np),
        .input_supply_ok(ok), .reg_wr_en(wen), .reg_rd_en(ren),
        .reg_addr(adr), .reg_wdata(wd), .i2c_stop(stp));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // k 0: rail gap, 1: positive ramp, 2: negative ramp
    function automatic int want(input int md, input int k);
        if (k == 0) return (md[0] || md == 4) ? 0 : TD;
        return md[1] ? ((k == 2) ? TN : TP) : TS;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, s);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // two cycles of slack: pipeline depth is the designer's choice
    task automatic chk_cyc(input string n, input int e, s);
        n_compared++;
        if (s < e - 2 || s > e + 2) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic power_on;
        {t_pos, t_neg, l_pos, l_neg} = {-32'sd1, -32'sd1, 32'd0, 32'd0};
        host.pins(1'b1, 1'b1, 1'b1);
        for (int c = 0; c < 200; c++) begin
            tick(1);
            if (pos === 1'b1 && t_pos < 0) t_pos = c;
            if (neg === 1'b1 && t_neg < 0) t_neg = c;
            l_pos += int'(pb === 1'b1);
            l_neg += int'(nb === 1'b1);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        host.rd(8'h02, v);
        chk("enable reset", 8'h07, v);
        for (m = 0; m < 5; m++) begin
            host.wr(8'h04, {3'h0, m[0], 4'h0}, 1'b1);
            host.wr(8'h05, {m[1], 2'h0, m[0], 4'h0}, 1'b1);
            host.wr(8'h02, (m == 4) ? 8'h47 : 8'h07, 1'b1);
            power_on();
            chk("positive on", 8'h01, pos);
            chk_cyc("rail gap", want(m, 0), t_neg - t_pos);
            chk_cyc("positive ramp", want(m, 1), l_pos);
            chk_cyc("negative ramp", want(m, 2), l_neg);
            host.pins(1'b1, 1'b0, 1'b1);
            tick(6);
            chk("negative off", 8'h00, neg);
            chk("discharge on", 8'h01, dis);
            tick(TD + 4);
            chk("discharge off", 8'h00, dis);
            host.pins(1'b0, 1'b0, 1'b1);
            tick(6);
            chk("discharge again", 8'h01, dis);
            chk("positive held", {7'h00, !m[0]}, pos);
            tick(TD + 4);
            chk("boost off", 8'h00, bst);
            tick(int'(lfsr[2:0]));
            lfsr = step(lfsr);
        end
        power_on();
        host.pins(1'b1, 1'b1, 1'b0);
        tick(5);
        chk("lockout", 8'h00, {5'h00, bst, pos, neg});
        host.pins(1'b1, 1'b1, 1'b1);
        tick(TB + 10);
        chk("restart", 8'h01, bst);
        host.pins(1'b0, 1'b0, 1'b1);
        tick(TD + 10);
        host.wr(8'h02, 8'h03, 1'b1);
        host.pins(1'b1, 1'b1, 1'b1);
        tick(TB + TD + 20);
        chk("positive gated", 8'h00, pos);
        chk("negative alone", 8'h01, neg);
        host.wr(8'h02, 8'h07, 1'b0);
        host.rd(8'h02, v);
        chk("staged", 8'h03, v);
        host.wr(8'h10, lfsr[15:8], 1'b1);
        host.rd(8'h10, v);
        chk("unmapped", 8'h00, v);
        tick(4);
        chk("committed", 8'h01, pos);
        report_and_stop();
    end
endmodule
`default_nettype wire
